// >>> pac_proximity_adc_config.sv
// Purpose: proximity conversion settings and per-conversion recovery/integration timing
// Assumes: sequencer drives conv_start on this clock; avalon-mm master honours waitrequest
// Notes:   settings are captured at conversion start so writes never disturb a running one
//
// Overview of operation
// [R01] second channel input select, eight bits, resets to 0x03
// [R02] third channel input select, eight bits, same code meanings
// [R03] normal mode accepts 0x03 large ir and 0x00 small ir photodiodes
// [R04] raw mode disables emitters and also accepts 0x02, 0x06, 0x25, 0x65, 0x75
// [R05] recovery wait before conversion: 1,7,15,31,63,127,255,511 adc clocks
// [R06] scale field multiplies emitter pulse and integration time by two to the code
// [R07] host keeps scale at 5 or below; hardware gives no protection
// [R08] range bit 5 selects high signal range, gain divided by 14.5
// [R09] mode bit 2 set is normal proximity, clear is raw; resets to 0x04
// [R10] recovery setting resets to zero, one adc clock wait
// [R11] host writes reserved bits as zero and ignores their read value
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module pac_proximity_adc_config #(
  parameter int REC_UNIT_CYC  = pac_pkg::CYC_PER_ADC,
  parameter int INTEG_BASE_CYC = pac_pkg::BASE_INTEG_ADC * pac_pkg::CYC_PER_ADC
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // avalon-mm slave
  input  wire logic [pac_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [pac_pkg::DATA_W-1:0]  avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [pac_pkg::DATA_W-1:0]       avs_readdata,
  output logic                             avs_waitrequest,
  // sequencer request
  input  wire logic                        conv_start,
  input  wire logic                        conv_chan_third,
  output logic                             conv_busy,
  output logic                             conv_done,
  output logic                             conv_refused,
  // analog front-end controls
  output logic [7:0]                       adc_input_code,
  output logic                             emitter_drive_en,
  output logic                             high_signal_range_select,
  output logic                             raw_or_normal_select,
  output logic                             recovering,
  output logic                             integrating
);

  // register file state
  logic [7:0]              second_sel_q;
  logic [7:0]              second_sel_d;
  logic [7:0]              third_sel_q;
  logic [7:0]              third_sel_d;
  logic [2:0]              recovery_clock_code_q;
  logic [2:0]              recovery_clock_code_d;
  logic [2:0]              scale_q;
  logic [2:0]              scale_d;
  logic                    range_q;
  logic                    range_d;
  logic                    mode_q;
  logic                    mode_d;
  logic                    refused_st_q;
  logic                    refused_st_d;
  logic                    done_st_q;
  logic                    done_st_d;
  logic                    ack_q;
  logic                    ack_d;
  logic [7:0]              rdata_q;
  logic [7:0]              rdata_d;

  // conversion state
  pac_pkg::pac_state_t     state_q;
  pac_pkg::pac_state_t     state_d;
  logic [7:0]              code_q;
  logic [7:0]              code_d;
  logic                    cap_normal_q;
  logic                    cap_normal_d;
  logic                    cap_range_q;
  logic                    cap_range_d;
  logic [2:0]              cap_scale_q;
  logic [2:0]              cap_scale_d;
  logic                    done_q;
  logic                    done_d;
  logic                    refused_q;
  logic                    refused_d;

  // timer hookup
  logic                    tmr_load;
  logic [pac_pkg::CNT_W-1:0] tmr_val;
  logic                    tmr_done;

  logic                    req;
  logic                    wr_take;
  logic [3:0]              idx;
  logic [7:0]              wbyte;
  logic [7:0]              pick_code;
  logic                    pick_ok;
  logic                    ev_done;
  logic                    ev_refused;

  assign req     = avs_read | avs_write;
  // one wait cycle: readdata is registered during it, write lands at the release edge
  assign avs_waitrequest = req & ~ack_q;
  assign wr_take = avs_write & ack_q & avs_byteenable[0];
  assign idx     = avs_address[pac_pkg::ADDR_W-1:pac_pkg::IDX_LSB];
  assign wbyte   = avs_writedata[7:0];

  // input code legality for the current mode
  function automatic logic code_legal(input logic [7:0] c, input logic normal);
    logic ok;
    ok = 1'b0;
    // [R03] normal mode codes
    if (c == pac_pkg::CODE_LARGE_IR || c == pac_pkg::CODE_SMALL_IR) begin
      ok = 1'b1;
    end
    // [R04] extra raw codes
    if (!normal) begin
      case (c)
        pac_pkg::CODE_VISIBLE,
        pac_pkg::CODE_NO_PD,
        pac_pkg::CODE_GND,
        pac_pkg::CODE_TEMP,
        pac_pkg::CODE_SUPPLY: ok = 1'b1;
        default:              ok = ok;
      endcase
    end
    return ok;
  endfunction : code_legal

  // register writes and status flags
  always_comb begin
    second_sel_d          = second_sel_q;
    third_sel_d           = third_sel_q;
    recovery_clock_code_d = recovery_clock_code_q;
    scale_d               = scale_q;
    range_d               = range_q;
    mode_d                = mode_q;
    refused_st_d          = refused_st_q;
    done_st_d             = done_st_q;
    if (wr_take) begin
      case (idx)
        // [R01] second channel select
        pac_pkg::IDX_SECOND_SEL: second_sel_d = wbyte;
        // [R02] third channel select
        pac_pkg::IDX_THIRD_SEL:  third_sel_d = wbyte;
        // [R05] recovery code field
        pac_pkg::IDX_RECOVERY: begin
          recovery_clock_code_d = wbyte[pac_pkg::REC_MSB:pac_pkg::REC_LSB];
        end
        // [R06] scale field; values above five are stored as written
        pac_pkg::IDX_SCALE:      scale_d = wbyte[pac_pkg::SCALE_MSB:0];
        // [R08] range and [R09] mode bits
        pac_pkg::IDX_RANGE_MODE: begin
          range_d = wbyte[pac_pkg::RANGE_BIT];
          mode_d  = wbyte[pac_pkg::MODE_BIT];
        end
        pac_pkg::IDX_STATUS: begin
          if (wbyte[pac_pkg::ST_REFUSED_BIT]) begin
            refused_st_d = 1'b0;
          end
          if (wbyte[pac_pkg::ST_DONE_BIT]) begin
            done_st_d = 1'b0;
          end
        end
        default: begin
          second_sel_d = second_sel_q;
        end
      endcase
    end
    // hardware set beats a same-cycle software clear
    if (ev_refused) begin
      refused_st_d = 1'b1;
    end
    if (ev_done) begin
      done_st_d = 1'b1;
    end
  end

  // read path, reserved bits read zero
  always_comb begin
    ack_d   = req & ~ack_q;
    rdata_d = rdata_q;
    if (avs_read & ~ack_q) begin
      case (idx)
        pac_pkg::IDX_SECOND_SEL: rdata_d = second_sel_q;
        pac_pkg::IDX_THIRD_SEL:  rdata_d = third_sel_q;
        pac_pkg::IDX_RECOVERY: begin
          rdata_d = '0;
          rdata_d[pac_pkg::REC_MSB:pac_pkg::REC_LSB] = recovery_clock_code_q;
        end
        pac_pkg::IDX_SCALE: begin
          rdata_d = '0;
          rdata_d[pac_pkg::SCALE_MSB:0] = scale_q;
        end
        pac_pkg::IDX_RANGE_MODE: begin
          rdata_d = '0;
          rdata_d[pac_pkg::RANGE_BIT] = range_q;
          rdata_d[pac_pkg::MODE_BIT]  = mode_q;
        end
        pac_pkg::IDX_STATUS: begin
          rdata_d = '0;
          rdata_d[pac_pkg::ST_REFUSED_BIT]  = refused_st_q;
          rdata_d[pac_pkg::ST_DONE_BIT]     = done_st_q;
          // [R07] advisory only, nothing is blocked
          rdata_d[pac_pkg::ST_SCALE_HI_BIT] = (scale_q > pac_pkg::SCALE_SAFE_MAX);
          rdata_d[pac_pkg::ST_BUSY_BIT]     = (state_q != pac_pkg::PAC_IDLE);
        end
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      // [R01] second select reset
      second_sel_q          <= pac_pkg::RST_SECOND_SEL;
      third_sel_q           <= pac_pkg::RST_THIRD_SEL;
      // [R10] recovery reset to zero
      recovery_clock_code_q <= pac_pkg::RST_RECOVERY[pac_pkg::REC_MSB:pac_pkg::REC_LSB];
      scale_q               <= pac_pkg::RST_SCALE[pac_pkg::SCALE_MSB:0];
      // [R09] range and mode reset
      range_q               <= pac_pkg::RST_RANGE_MODE[pac_pkg::RANGE_BIT];
      mode_q                <= pac_pkg::RST_RANGE_MODE[pac_pkg::MODE_BIT];
      refused_st_q          <= 1'b0;
      done_st_q             <= 1'b0;
      ack_q                 <= 1'b0;
      rdata_q               <= 8'h00;
    end else begin
      second_sel_q          <= second_sel_d;
      third_sel_q           <= third_sel_d;
      recovery_clock_code_q <= recovery_clock_code_d;
      scale_q               <= scale_d;
      range_q               <= range_d;
      mode_q                <= mode_d;
      refused_st_q          <= refused_st_d;
      done_st_q             <= done_st_d;
      ack_q                 <= ack_d;
      rdata_q               <= rdata_d;
    end
  end

  assign avs_readdata = {{(pac_pkg::DATA_W-8){1'b0}}, rdata_q};

  // conversion sequencing
  assign pick_code  = conv_chan_third ? third_sel_q : second_sel_q;
  assign pick_ok    = code_legal(pick_code, mode_q);
  assign ev_done    = (state_q == pac_pkg::PAC_INTEG) & tmr_done;
  assign ev_refused = (state_q == pac_pkg::PAC_IDLE) & conv_start & ~pick_ok;

  always_comb begin
    state_d      = state_q;
    code_d       = code_q;
    cap_normal_d = cap_normal_q;
    cap_range_d  = cap_range_q;
    cap_scale_d  = cap_scale_q;
    done_d       = ev_done;
    refused_d    = ev_refused;
    tmr_load     = 1'b0;
    tmr_val      = '0;
    case (state_q)
      pac_pkg::PAC_IDLE: begin
        if (conv_start && pick_ok) begin
          code_d       = pick_code;
          cap_normal_d = mode_q;
          cap_range_d  = range_q;
          cap_scale_d  = scale_q;
          // [R05] recovery wait length
          tmr_load     = 1'b1;
          tmr_val      = pac_pkg::CNT_W'(
            int'(pac_pkg::rec_adc_clks(recovery_clock_code_q)) * REC_UNIT_CYC);
          state_d      = pac_pkg::PAC_RECOVER;
        end
      end
      pac_pkg::PAC_RECOVER: begin
        if (tmr_done) begin
          // [R06] integration scaled by power of two
          tmr_load = 1'b1;
          tmr_val  = pac_pkg::CNT_W'(INTEG_BASE_CYC) << cap_scale_q;
          state_d  = pac_pkg::PAC_INTEG;
        end
      end
      pac_pkg::PAC_INTEG: begin
        if (tmr_done) begin
          state_d = pac_pkg::PAC_IDLE;
        end
      end
      default: state_d = pac_pkg::PAC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q      <= pac_pkg::PAC_IDLE;
      code_q       <= pac_pkg::RST_SECOND_SEL;
      cap_normal_q <= 1'b1;
      cap_range_q  <= 1'b0;
      cap_scale_q  <= 3'h0;
      done_q       <= 1'b0;
      refused_q    <= 1'b0;
    end else begin
      state_q      <= state_d;
      code_q       <= code_d;
      cap_normal_q <= cap_normal_d;
      cap_range_q  <= cap_range_d;
      cap_scale_q  <= cap_scale_d;
      done_q       <= done_d;
      refused_q    <= refused_d;
    end
  end

  pac_cycle_timer u_timer (
    .clk      (clk),
    .srst     (srst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .busy     (),
    .done     (tmr_done)
  );

  assign conv_busy                = (state_q != pac_pkg::PAC_IDLE);
  assign conv_done                = done_q;
  assign conv_refused             = refused_q;
  assign adc_input_code           = code_q;
  assign recovering               = (state_q == pac_pkg::PAC_RECOVER);
  assign integrating              = (state_q == pac_pkg::PAC_INTEG);
  // [R04] emitters held off in raw mode; [R06] pulse spans the scaled integration
  assign emitter_drive_en         = integrating & cap_normal_q;
  // [R08] range follows captured bit
  assign high_signal_range_select = cap_range_q;
  // [R09] 1 = normal proximity, 0 = raw
  assign raw_or_normal_select     = cap_normal_q;

endmodule : pac_proximity_adc_config
`default_nettype wire

// >>> pac_pkg.sv
// Purpose: shared constants and types for the proximity conversion settings block
// Assumes: 250 MHz system clock, 32-bit avalon-mm register window
// Notes:   register indices are word indices; byte address is four times the index
package pac_pkg;

  // register window
  localparam int          ADDR_W = 6;
  localparam int          DATA_W = 32;
  localparam int          IDX_LSB = 2;
  localparam logic [3:0]  IDX_SECOND_SEL = 4'h8;
  localparam logic [3:0]  IDX_THIRD_SEL  = 4'h9;
  localparam logic [3:0]  IDX_RECOVERY   = 4'hA;
  localparam logic [3:0]  IDX_SCALE      = 4'hB;
  localparam logic [3:0]  IDX_RANGE_MODE = 4'hC;
  localparam logic [3:0]  IDX_STATUS     = 4'hD;

  // reset values
  localparam logic [7:0]  RST_SECOND_SEL = 8'h03;
  localparam logic [7:0]  RST_THIRD_SEL  = 8'h03;
  localparam logic [7:0]  RST_RECOVERY   = 8'h00;
  localparam logic [7:0]  RST_SCALE      = 8'h00;
  localparam logic [7:0]  RST_RANGE_MODE = 8'h04;

  // field positions
  localparam int          REC_LSB   = 4;
  localparam int          REC_MSB   = 6;
  localparam int          SCALE_MSB = 2;
  localparam int          RANGE_BIT = 5;
  localparam int          MODE_BIT  = 2;

  // status bits
  localparam int          ST_REFUSED_BIT  = 0;
  localparam int          ST_DONE_BIT     = 1;
  localparam int          ST_SCALE_HI_BIT = 2;
  localparam int          ST_BUSY_BIT     = 3;

  // input select codes
  localparam logic [7:0]  CODE_SMALL_IR = 8'h00;
  localparam logic [7:0]  CODE_VISIBLE  = 8'h02;
  localparam logic [7:0]  CODE_LARGE_IR = 8'h03;
  localparam logic [7:0]  CODE_NO_PD    = 8'h06;
  localparam logic [7:0]  CODE_GND      = 8'h25;
  localparam logic [7:0]  CODE_TEMP     = 8'h65;
  localparam logic [7:0]  CODE_SUPPLY   = 8'h75;

  localparam logic [2:0]  SCALE_SAFE_MAX = 3'h5;

  // timing
  localparam int          CLK_PERIOD_PS   = 4000;
  localparam int          ADC_CLK_PS      = 50000;
  localparam int          CYC_PER_ADC     = (ADC_CLK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          BASE_INTEG_ADC  = 512;
  localparam int          CNT_W           = 24;

  typedef enum logic [1:0] {
    PAC_IDLE,
    PAC_RECOVER,
    PAC_INTEG
  } pac_state_t;

  // recovery length in adc clocks for each code
  function automatic logic [9:0] rec_adc_clks(input logic [2:0] code);
    logic [9:0] r;
    case (code)
      3'h0:    r = 10'h001;
      3'h1:    r = 10'h007;
      3'h2:    r = 10'h00F;
      3'h3:    r = 10'h01F;
      3'h4:    r = 10'h03F;
      3'h5:    r = 10'h07F;
      3'h6:    r = 10'h0FF;
      default: r = 10'h1FF;
    endcase
    return r;
  endfunction : rec_adc_clks

endpackage : pac_pkg

// >>> pac_cycle_timer.sv
// Purpose: down-counter whose done marks the last of a loaded number of cycles
// Assumes: load value of zero is treated as one
// Notes:   a new load restarts the count
`timescale 1ns/1ps
`default_nettype none
module pac_cycle_timer (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    srst,
  // control
  input  wire logic                    load,
  input  wire logic [pac_pkg::CNT_W-1:0] load_val,
  // status
  output logic                         busy,
  output logic                         done
);

  logic [pac_pkg::CNT_W-1:0] cnt_q;
  logic [pac_pkg::CNT_W-1:0] cnt_d;
  logic                      busy_q;
  logic                      busy_d;
  logic                      last;

  // done is decoded in the last counted cycle; a registered done would add a cycle per phase
  assign last = busy_q & (cnt_q == pac_pkg::CNT_W'(1));

  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    if (load) begin
      cnt_d  = (load_val == '0) ? pac_pkg::CNT_W'(1) : load_val;
      busy_d = 1'b1;
    end else if (last) begin
      cnt_d  = '0;
      busy_d = 1'b0;
    end else if (busy_q) begin
      cnt_d = cnt_q - pac_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign busy = busy_q;
  assign done = last;

endmodule : pac_cycle_timer
`default_nettype wire

// >>> pac_chk.sv
// Purpose: port-level checker for the proximity conversion settings block
// Assumes: single clock domain, synchronous active-high reset
// Notes:   shadows recovery and scale writes to time each conversion
`timescale 1ns/1ps
`default_nettype none
module pac_chk #(
  parameter int REC_UNIT_CYC   = 1,
  parameter int INTEG_BASE_CYC = 2
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // avalon-mm slave
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // sequencer and front end
  input wire logic        conv_start,
  input wire logic        conv_chan_third,
  input wire logic        conv_busy,
  input wire logic        conv_done,
  input wire logic        conv_refused,
  input wire logic [7:0]  adc_input_code,
  input wire logic        emitter_drive_en,
  input wire logic        high_signal_range_select,
  input wire logic        raw_or_normal_select,
  input wire logic        recovering,
  input wire logic        integrating
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [2:0] rec_w_q, scl_w_q, rec_c_q, scl_c_q;
  int         cnt_q;
  logic       wr_ok;
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  function automatic int rec_len(input logic [2:0] c);
    return (c == 3'h0) ? 1 : (1 << (c + 2)) - 1;
  endfunction : rec_len
  // settings are captured at an idle start, so the shadow follows that
  always_ff @(posedge clk) begin
    if (srst) begin
      rec_w_q <= 3'h0;
      scl_w_q <= 3'h0;
      rec_c_q <= 3'h0;
      scl_c_q <= 3'h0;
      cnt_q   <= 32'h0;
    end else begin
      if (wr_ok && avs_address[5:2] == pac_pkg::IDX_RECOVERY) rec_w_q <= avs_writedata[6:4];
      if (wr_ok && avs_address[5:2] == pac_pkg::IDX_SCALE) scl_w_q <= avs_writedata[2:0];
      if (conv_start && !conv_busy) begin
        rec_c_q <= rec_w_q;
        scl_c_q <= scl_w_q;
        cnt_q   <= 32'h0;
      end else if (conv_busy) cnt_q <= cnt_q + 1;
    end
  end
  sequence s_rec_end; recovering ##1 !recovering; endsequence
  sequence s_int_end; integrating ##1 !integrating; endsequence
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("bus answered without wait");
  rd_upper_a: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  start_take_a: assert property (conv_start && !conv_busy |=> recovering ^ conv_refused)
    else $error("idle start neither accepted nor refused");
  rec_integ_a: assert property (s_rec_end |-> integrating)
    else $error("recovery not followed by integration");
  done_after_a: assert property (s_int_end |-> conv_done && !conv_busy)
    else $error("done missing after integration");
  emit_mode_a: assert property (emitter_drive_en == (integrating && raw_or_normal_select))
    else $error("emitter drive wrong for mode");
  busy_dec_a: assert property (conv_busy == (recovering || integrating))
    else $error("busy not recovery or integration");
  cfg_hold_a: assert property (conv_busy && $past(conv_busy) |->
    $stable(adc_input_code) && $stable(high_signal_range_select)
    && $stable(raw_or_normal_select))
    else $error("captured settings moved while busy");
  conv_len_a: assert property (conv_done |->
    cnt_q == rec_len(rec_c_q) * REC_UNIT_CYC + (INTEG_BASE_CYC << scl_c_q))
    else $error("conversion length wrong");
  pulse_one_a: assert property (conv_done || conv_refused |=> !conv_done && !conv_refused)
    else $error("status pulse longer than one cycle");
endmodule : pac_chk
bind pac_proximity_adc_config pac_chk #(.REC_UNIT_CYC(REC_UNIT_CYC),
  .INTEG_BASE_CYC(INTEG_BASE_CYC)) u_chk (.*);
`default_nettype wire

// >>> pac_tb.sv
// Purpose: self-checking bench for the proximity conversion settings block
// Assumes: shortened timing, one cycle per adc clock, base integration of two
// Notes:   status flags are read back and cleared after the conversion run
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, srst, rd_s, wr_s, start, third;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  be;
  logic        wait_r, busy, done, refused, emit, hsr, ron, recv, integ, e, ok;
  logic [7:0]  code, c;
  logic [7:0]  mdl [16];
  logic [7:0]  msk [16];
  logic [7:0]  codes [8] = '{8'h00, 8'h02, 8'h03, 8'h06, 8'h25, 8'h65, 8'h75, 8'h01};
  logic [3:0]  ix;
  logic [2:0]  s;
  logic        r;
  int          n_errors, tests_run, seed, n;
  pac_proximity_adc_config #(.REC_UNIT_CYC(1), .INTEG_BASE_CYC(2)) u_dut (
    .clk(clk), .srst(srst), .avs_address(addr), .avs_read(rd_s), .avs_write(wr_s),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wait_r), .conv_start(start), .conv_chan_third(third),
    .conv_busy(busy), .conv_done(done), .conv_refused(refused), .adc_input_code(code),
    .emitter_drive_en(emit), .high_signal_range_select(hsr),
    .raw_or_normal_select(ron), .recovering(recv), .integrating(integ));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // one bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] i, input logic [31:0] wd,
                     input logic [3:0] b, output logic [31:0] q);
    int k;
    @(posedge clk);
    addr  <= {i, 2'h0};
    wr_s  <= wr;
    rd_s  <= !wr;
    wdata <= wd;
    be    <= b;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wait_r !== 1'b0 && k < 100);
    if (k >= 100) begin
      n_errors++;
      report_and_stop();
    end
    q = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    if (wr && b[0]) mdl[i] = wd[7:0] & msk[i];
  endtask : bus
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    seed = 32'hFA5C;
    {rd_s, wr_s, start, third, addr, wdata, be} = '0;
    for (int i = 0; i < 16; i++) msk[i] = 8'h00;
    msk[8] = 8'hFF;
    msk[9] = 8'hFF;
    msk[10] = 8'h70;
    msk[11] = 8'h07;
    msk[12] = 8'h24;
    for (int i = 0; i < 16; i++) mdl[i] = 8'h00;
    mdl[8] = 8'h03;
    mdl[9] = 8'h03;
    mdl[12] = 8'h04;
    srst = 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 16; i++) if (i != 13) begin
      bus(1'b0, i[3:0], 32'h0, 4'hF, rd);
      chk(rd, {24'h0, mdl[i]});
    end
    for (int k = 0; k < 24; k++) begin
      ix = $random(seed);
      if (ix == 4'hD) ix = 4'hE;
      // reserved positions are written as zero, as the host must
      bus(1'b1, ix, $random(seed) & {24'h0, msk[ix]}, $random(seed), rd);
      bus(1'b0, ix, 32'h0, 4'hF, rd);
      chk(rd, {24'h0, mdl[ix]});
    end
    for (int m = 0; m < 2; m++) for (int j = 0; j < 8; j++) begin
      c = codes[j];
      r = $random(seed);
      s = $random(seed) & 3;
      bus(1'b1, 4'hC, {26'h0, r, 2'h0, m[0], 2'h0}, 4'h1, rd);
      bus(1'b1, 4'h8 + j[0], {24'h0, c}, 4'h1, rd);
      bus(1'b1, 4'hA, {25'h0, j[2:0], 4'h0}, 4'h1, rd);
      bus(1'b1, 4'hB, {29'h0, s}, 4'h1, rd);
      @(posedge clk);
      start <= 1'b1;
      third <= j[0];
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      ok = m ? (c == 8'h00 || c == 8'h03) : (c != 8'h01);
      chk(refused, !ok);
      chk({busy, recv}, {ok, ok});
      if (ok) begin
        chk(code, c);
        chk(ron, m);
        chk(hsr, r);
        n = 1;
        e = 1'b0;
        while (done !== 1'b1 && n < 2000) begin
          if (integ === 1'b1) e = e | emit;
          @(posedge clk);
          n++;
        end
        chk(n, ((j == 0) ? 1 : (1 << (j + 2)) - 1) + (2 << s) + 1);
        chk(e, m);
        chk(busy, 1'b0);
      end
    end
    // scale above the safe limit is stored as written; only the status flag shows it
    bus(1'b0, 4'hD, 32'h0, 4'hF, rd);
    chk(rd, 32'h3);
    bus(1'b1, 4'hD, 32'h3, 4'h1, rd);
    bus(1'b1, 4'hB, 32'h6, 4'h1, rd);
    bus(1'b0, 4'hD, 32'h0, 4'hF, rd);
    chk(rd, 32'h4);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
